// file: pkg/pifr_pkg.sv
// constants and types shared by the peripheral interrupt flag register design
`default_nettype none
package pifr_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] FLAGS_OFF   = 8'h0C;
  localparam logic [ADDR_W-1:0] ENABLES_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] CTRL_OFF    = 8'h14;
  localparam logic [ADDR_W-1:0] CLEAR_OFF   = 8'h18;
  localparam logic [ADDR_W-1:0] PENDING_OFF = 8'h1C;
  //////////////////////////////////////////////////////////////////////////////
  // flag bit positions, and the gate bit of the control register
  localparam int CONV_BIT   = 6;
  localparam int SERIAL_BIT = 3;
  localparam int CCP_BIT    = 2;
  localparam int PERIOD_BIT = 1;
  localparam int OVF_BIT    = 0;
  localparam int GATE_BIT   = 0;
  // implemented flag bits; 7, 5 and 4 read zero
  localparam logic [REG_W-1:0] IMPL_MASK   = 8'h4F;
  // values after reset
  localparam logic [REG_W-1:0] FLAGS_RST   = 8'h00;
  localparam logic [REG_W-1:0] ENABLES_RST = 8'h00;
  localparam logic             GATE_RST    = 1'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  //////////////////////////////////////////////////////////////////////////////
  // operating mode of the capture/compare unit
  typedef enum logic [1:0] {
    PIFR_CAPTURE,
    PIFR_COMPARE,
    PIFR_PWM,
    PIFR_OFF
  } pifr_ccp_mode_t;
endpackage
`default_nettype wire

// file: pkg/pifr_evt_if.sv
// carrier of the per-bit set requests from the event mapper
`default_nettype none
interface pifr_evt_if;
  logic [7:0] set_vec;
  modport src (output set_vec);
  modport dst (input set_vec);
endinterface
`default_nettype wire

// file: pkg/pifr_irq_if.sv
// carrier between the register file and the interrupt gate
`default_nettype none
interface pifr_irq_if;
  logic [7:0] flags;
  logic [7:0] enables;
  logic       gate;
  logic       irq;
  modport regs (output flags, output enables, output gate, input irq);
  modport gate_side (input flags, input enables, input gate, output irq);
endinterface
`default_nettype wire

// file: core/pifr_event_map.sv
// maps peripheral event pulses onto flag set requests
`default_nettype none
module pifr_event_map (
  input  wire logic                    conversion_event_i,
  input  wire logic                    serial_port_event_i,
  input  wire logic                    capture_event_i,
  input  wire logic                    compare_event_i,
  input  wire pifr_pkg::pifr_ccp_mode_t capture_compare_mode_i,
  input  wire logic                    period_match_event_i,
  input  wire logic                    timer_overflow_event_i,
  pifr_evt_if.src                      evt
);
  import pifr_pkg::*;

  // events set flags whatever the enables say; gating lives downstream
  always_comb begin
    evt.set_vec             = '0;
    evt.set_vec[CONV_BIT]   = conversion_event_i;
    evt.set_vec[SERIAL_BIT] = serial_port_event_i;
    evt.set_vec[PERIOD_BIT] = period_match_event_i;
    evt.set_vec[OVF_BIT]    = timer_overflow_event_i;
    // the shared bit follows the unit's mode; pulse-width mode leaves it alone
    case (capture_compare_mode_i)
      PIFR_CAPTURE: evt.set_vec[CCP_BIT] = capture_event_i;
      PIFR_COMPARE: evt.set_vec[CCP_BIT] = compare_event_i;
      default:      evt.set_vec[CCP_BIT] = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: core/pifr_irq_gate.sv
// registered interrupt request from flags, enables and the peripheral gate
`default_nettype none
module pifr_irq_gate (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     ce_i,
  pifr_irq_if.gate_side g
);
  import pifr_pkg::*;

  // registered so the top-level output comes straight from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g.irq <= 1'b0;
    end else if (ce_i) begin
      g.irq <= g.gate & (|(g.flags & g.enables));
    end
  end
endmodule
`default_nettype wire

// file: core/pifr_top.sv
// peripheral interrupt flag register with an AXI4-Lite slave
`default_nettype none
module pifr_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // write address channel
  input  wire logic [pifr_pkg::ADDR_W-1:0] s_axil_awaddr_i,
  input  wire logic [2:0]                s_axil_awprot_i,
  input  wire logic                      s_axil_awvalid_i,
  output var  logic                      s_axil_awready_o,
  // write data channel
  input  wire logic [pifr_pkg::DATA_W-1:0] s_axil_wdata_i,
  input  wire logic [3:0]                s_axil_wstrb_i,
  input  wire logic                      s_axil_wvalid_i,
  output var  logic                      s_axil_wready_o,
  // write response channel
  output var  logic [1:0]                s_axil_bresp_o,
  output var  logic                      s_axil_bvalid_o,
  input  wire logic                      s_axil_bready_i,
  // read address channel
  input  wire logic [pifr_pkg::ADDR_W-1:0] s_axil_araddr_i,
  input  wire logic [2:0]                s_axil_arprot_i,
  input  wire logic                      s_axil_arvalid_i,
  output var  logic                      s_axil_arready_o,
  // read data channel
  output var  logic [pifr_pkg::DATA_W-1:0] s_axil_rdata_o,
  output var  logic [1:0]                s_axil_rresp_o,
  output var  logic                      s_axil_rvalid_o,
  input  wire logic                      s_axil_rready_i,
  // peripheral events, one-cycle pulses from logic on clk_i, plus the capture/compare mode select
  input  wire logic                      conversion_event_i,
  input  wire logic                      serial_port_event_i,
  input  wire logic                      capture_event_i,
  input  wire logic                      compare_event_i,
  input  wire pifr_pkg::pifr_ccp_mode_t  capture_compare_mode_i,
  input  wire logic                      period_match_event_i,
  input  wire logic                      timer_overflow_event_i,
  // level interrupt to the processor
  output var  logic                      irq_o
);
  import pifr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state and internal signals

  logic [REG_W-1:0]  peripheral_event_flags;
  logic [REG_W-1:0]  peripheral_irq_enables;
  logic              peripheral_irq_gate;
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [DATA_W-1:0] w_data;
  logic [3:0]        w_strb;
  logic              w_full;
  logic              do_wr;
  logic              wr_lane0;
  logic              wr_hit_flags;
  logic              wr_hit_enables;
  logic              wr_hit_ctrl;
  logic              wr_hit_clear;
  logic              wr_mapped;
  logic [REG_W-1:0]  wr_byte;
  logic [REG_W-1:0]  next_flags;
  logic [DATA_W-1:0] rd_word;
  logic              rd_mapped;

  pifr_evt_if evt ();
  pifr_irq_if irqc ();

  //////////////////////////////////////////////////////////////////////////////
  // event qualification and interrupt gating

  pifr_event_map u_event_map (
    .conversion_event_i     (conversion_event_i),
    .serial_port_event_i    (serial_port_event_i),
    .capture_event_i        (capture_event_i),
    .compare_event_i        (compare_event_i),
    .capture_compare_mode_i (capture_compare_mode_i),
    .period_match_event_i   (period_match_event_i),
    .timer_overflow_event_i (timer_overflow_event_i),
    .evt                    (evt)
  );

  // register state handed to the gate
  assign irqc.flags   = peripheral_event_flags;
  assign irqc.enables = peripheral_irq_enables;
  assign irqc.gate    = peripheral_irq_gate;

  pifr_irq_gate u_irq_gate (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .g     (irqc)
  );

  // the gate's flop drives the pin directly
  assign irq_o = irqc.irq;

  //////////////////////////////////////////////////////////////////////////////
  // write address channel: hold one address until the response is taken

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axil_awready_o <= 1'b1;
      aw_full          <= 1'b0;
      aw_addr          <= '0;
    end else if (ce_i) begin
      if (s_axil_awvalid_i && s_axil_awready_o) begin
        s_axil_awready_o <= 1'b0;
        aw_full          <= 1'b1;
        aw_addr          <= s_axil_awaddr_i;
      end else if (do_wr) begin
        aw_full <= 1'b0;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_awready_o <= 1'b1; // reopen only once the answer is gone
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write data channel: independent of the address, either may come first

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axil_wready_o <= 1'b1;
      w_full          <= 1'b0;
      w_data          <= '0;
      w_strb          <= '0;
    end else if (ce_i) begin
      if (s_axil_wvalid_i && s_axil_wready_o) begin
        s_axil_wready_o <= 1'b0;
        w_full          <= 1'b1;
        w_data          <= s_axil_wdata_i;
        w_strb          <= s_axil_wstrb_i;
      end else if (do_wr) begin
        w_full <= 1'b0;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_wready_o <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write decode; only byte lane 0 carries register bits

  assign do_wr          = aw_full & w_full & ~s_axil_bvalid_o;
  assign wr_lane0       = do_wr & w_strb[0];
  assign wr_byte        = w_data[REG_W-1:0];
  assign wr_hit_flags   = aw_addr[ADDR_W-1:2] == FLAGS_OFF[ADDR_W-1:2];
  assign wr_hit_enables = aw_addr[ADDR_W-1:2] == ENABLES_OFF[ADDR_W-1:2];
  assign wr_hit_ctrl    = aw_addr[ADDR_W-1:2] == CTRL_OFF[ADDR_W-1:2];
  assign wr_hit_clear   = aw_addr[ADDR_W-1:2] == CLEAR_OFF[ADDR_W-1:2];
  // the pending view is read-only but a write to it is still answered OKAY
  assign wr_mapped = wr_hit_flags | wr_hit_enables | wr_hit_ctrl | wr_hit_clear
                   | (aw_addr[ADDR_W-1:2] == PENDING_OFF[ADDR_W-1:2]);

  //////////////////////////////////////////////////////////////////////////////
  // write response

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axil_bvalid_o <= 1'b0;
      s_axil_bresp_o  <= RESP_OKAY;
    end else if (ce_i) begin
      if (do_wr) begin
        s_axil_bvalid_o <= 1'b1;
        s_axil_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_bvalid_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag next value, one generate step per bit
  // a direct write stores the byte (zero clears, one sets by software);
  // the clear alias drops bits written as one; an event in the same cycle
  // always wins, so a pulse is never lost to a racing clear

  for (genvar i = 0; i < REG_W; i++) begin : g_flag
    if (IMPL_MASK[i]) begin : g_impl
      always_comb begin
        next_flags[i] = peripheral_event_flags[i];
        if (wr_lane0 && wr_hit_flags) begin
          next_flags[i] = wr_byte[i];
        end else if (wr_lane0 && wr_hit_clear && wr_byte[i]) begin
          next_flags[i] = 1'b0;
        end
        next_flags[i] = next_flags[i] | evt.set_vec[i];
      end
    end else begin : g_unimpl
      assign next_flags[i] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky flag register; nothing but reset or a software write ever clears a bit

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_event_flags <= FLAGS_RST;
    end else if (ce_i) begin
      peripheral_event_flags <= next_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable mask and peripheral gate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_irq_enables <= ENABLES_RST;
      peripheral_irq_gate    <= GATE_RST;
    end else if (ce_i) begin
      if (wr_lane0 && wr_hit_enables) begin
        peripheral_irq_enables <= wr_byte & IMPL_MASK;
      end
      if (wr_lane0 && wr_hit_ctrl) begin
        peripheral_irq_gate <= wr_byte[GATE_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unused bits read zero

  always_comb begin
    rd_word   = '0;
    rd_mapped = 1'b1;
    case (s_axil_araddr_i[ADDR_W-1:2])
      FLAGS_OFF[ADDR_W-1:2]:   rd_word[REG_W-1:0] = peripheral_event_flags;
      CLEAR_OFF[ADDR_W-1:2]:   rd_word[REG_W-1:0] = peripheral_event_flags;
      ENABLES_OFF[ADDR_W-1:2]: rd_word[REG_W-1:0] = peripheral_irq_enables;
      CTRL_OFF[ADDR_W-1:2]:    rd_word[GATE_BIT]  = peripheral_irq_gate;
      PENDING_OFF[ADDR_W-1:2]: rd_word[REG_W-1:0] = peripheral_event_flags
                                                  & peripheral_irq_enables;
      default:                 rd_mapped          = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data sampled at the address edge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axil_arready_o <= 1'b1;
      s_axil_rvalid_o  <= 1'b0;
      s_axil_rdata_o   <= '0;
      s_axil_rresp_o   <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axil_arvalid_i && s_axil_arready_o) begin
        s_axil_arready_o <= 1'b0;
        s_axil_rvalid_o  <= 1'b1;
        s_axil_rdata_o   <= rd_word;
        s_axil_rresp_o   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_rvalid_o && s_axil_rready_i) begin
        s_axil_rvalid_o  <= 1'b0;
        s_axil_arready_o <= 1'b1;
      end
    end
  end

  // protection bits are accepted and ignored
  logic unused_prot;
  assign unused_prot = ^{s_axil_awprot_i, s_axil_arprot_i, w_strb[3:1], w_data[DATA_W-1:REG_W]};

endmodule
`default_nettype wire

// file: tb/pifr_top_asserts.sv
// port-level assertion checker for the peripheral interrupt flag register
`default_nettype none
module pifr_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        s_axil_awvalid_i,
  input wire logic        s_axil_awready_o,
  input wire logic        s_axil_wvalid_i,
  input wire logic        s_axil_wready_o,
  input wire logic        s_axil_bvalid_o,
  input wire logic        s_axil_arvalid_i,
  input wire logic        s_axil_arready_o,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic        s_axil_rvalid_o,
  input wire logic        conversion_event_i,
  input wire logic        serial_port_event_i,
  input wire logic        capture_event_i,
  input wire logic        compare_event_i,
  input wire logic        period_match_event_i,
  input wire logic        timer_overflow_event_i,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic any_ev;

  // any peripheral pulse; mode filtering is left to the bench model
  assign any_ev = conversion_event_i | serial_port_event_i | capture_event_i | compare_event_i
                | period_match_event_i | timer_overflow_event_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // read data: only the low byte carries flags, holes read zero
  rd_upper_zero_a: assert property (s_axil_rvalid_o |-> s_axil_rdata_o[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  rd_holes_zero_a: assert property (s_axil_rvalid_o |-> s_axil_rdata_o[7] == 1'b0
                                    && s_axil_rdata_o[5:4] == 2'h0)
    else $error("unimplemented flag bits read nonzero");
  // bus answer times
  rd_latency_a: assert property (s_axil_arvalid_i && s_axil_arready_o && ce_i |=> s_axil_rvalid_o)
    else $error("read answer late");
  wr_latency_a: assert property (s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i && s_axil_wready_o
                                 && ce_i |-> ##2 s_axil_bvalid_o)
    else $error("write answer late");
  wr_resp_order_a: assert property ($rose(s_axil_bvalid_o) |->
                                    !$past(s_axil_awready_o) && !$past(s_axil_wready_o))
    else $error("write answered before both channels taken");
  // state right after reset release
  rst_idle_a: assert property ($fell(rst_i) |->
                               !irq_o && !s_axil_bvalid_o && !s_axil_rvalid_o && s_axil_awready_o)
    else $error("outputs not idle after reset");
  // the interrupt only drops after software wrote something; the releasing
  // edge still sees reset sampled high while irq has just been cleared by it
  irq_fall_cause_a: assert property (!rst_i && $fell(irq_o) |-> $past(s_axil_bvalid_o))
    else $error("interrupt dropped without a write");
  // it only rises two cycles after an event or right after a write
  irq_rise_cause_a: assert property ($rose(irq_o) |-> $past(any_ev, 2) || $past(s_axil_bvalid_o))
    else $error("interrupt rose without a cause");

  cover property ($rose(irq_o));
  cover property ($fell(irq_o));
  cover property (s_axil_rvalid_o && s_axil_rdata_o[6]);
endmodule

bind pifr_top pifr_top_asserts u_chk (.clk_i, .rst_i, .ce_i, .s_axil_awvalid_i, .s_axil_awready_o, .s_axil_wvalid_i,
  .s_axil_wready_o, .s_axil_bvalid_o, .s_axil_arvalid_i, .s_axil_arready_o, .s_axil_rdata_o, .s_axil_rvalid_o,
  .conversion_event_i, .serial_port_event_i, .capture_event_i, .compare_event_i, .period_match_event_i,
  .timer_overflow_event_i, .irq_o);
`default_nettype wire

// file: tb/pifr_test.sv
// self-checking bench for the peripheral interrupt flag register
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module pifr_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pifr_pkg::*;
  logic           clk_i, rst_i, ce, awvalid, wvalid, bready, arvalid, rready;
  logic           awready, wready, bvalid, arready, rvalid, irq, m_gt;
  logic [7:0]     awaddr, araddr, m_flg, m_en;
  logic [31:0]    wdata, rdata;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp;
  logic [5:0]     ev;
  pifr_ccp_mode_t mode;
  int             miscompares, n_tests, seed, cyc;
  logic [7:0]     addrs [6] = '{FLAGS_OFF, ENABLES_OFF, CTRL_OFF, CLEAR_OFF, PENDING_OFF, 8'h20};

  pifr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .s_axil_awaddr_i(awaddr), .s_axil_awprot_i(3'h0), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid), .s_axil_wready_o(wready),
    .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready),
    .s_axil_araddr_i(araddr), .s_axil_arprot_i(3'h0), .s_axil_arvalid_i(arvalid), .s_axil_arready_o(arready),
    .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
    .conversion_event_i(ev[5]), .serial_port_event_i(ev[4]), .capture_event_i(ev[3]), .compare_event_i(ev[2]),
    .capture_compare_mode_i(mode), .period_match_event_i(ev[1]), .timer_overflow_event_i(ev[0]), .irq_o(irq));
  //////////////////////////////////////////////////////////////////////////////
  // reference model of the register map
  function automatic logic map_ok(input logic [7:0] a);
    return a inside {FLAGS_OFF, ENABLES_OFF, CTRL_OFF, CLEAR_OFF, PENDING_OFF};
  endfunction
  function automatic logic [31:0] m_rd(input logic [7:0] a);
    case (a)
      FLAGS_OFF, CLEAR_OFF: return {24'h000000, m_flg};
      ENABLES_OFF: return {24'h000000, m_en};
      CTRL_OFF: return {31'h00000000, m_gt};
      PENDING_OFF: return {24'h000000, m_flg & m_en};
      default: return 32'h00000000;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // bus master: both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    forever begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    `CHK(bresp, map_ok(a) ? RESP_OKAY : RESP_SLVERR)
    if (s[0]) begin
      case (a)
        FLAGS_OFF: m_flg = d[7:0] & IMPL_MASK;
        ENABLES_OFF: m_en = d[7:0] & IMPL_MASK;
        CTRL_OFF: m_gt = d[0];
        CLEAR_OFF: m_flg = m_flg & ~d[7:0];
        default: ;
      endcase
    end
  endtask
  task automatic rchk(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    forever begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    `CHK(rdata, m_rd(a))
    `CHK(rresp, map_ok(a) ? RESP_OKAY : RESP_SLVERR)
  endtask
  // reads every place back, then the interrupt level
  task automatic chk_all;
    foreach (addrs[i]) rchk(addrs[i]);
    `CHK(irq, m_gt && |(m_flg & m_en))
  endtask
  // one-cycle event pulses; capture and compare count only in their own mode
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 6'h00;
    m_flg = m_flg | {1'b0, v[5], 2'h0, v[4], (v[3] && mode == PIFR_CAPTURE) || (v[2] && mode == PIFR_COMPARE), v[1:0]};
  endtask
  task automatic end_sim;
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      end_sim;
    end
  end
  // main sequence
  initial begin
    {miscompares, n_tests, cyc} = '0;
    seed = 20163;
    {awvalid, wvalid, bready, arvalid, rready, rst_i} = 6'h01;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb, ev, m_flg, m_en, m_gt} = '0;
    mode = PIFR_CAPTURE;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_all;
    wr(8'h04, 32'h000000FF, 4'hF);
    // each event alone in every mode, all masked: flags still set and stay set
    for (int m = 0; m < 4; m++) begin
      mode <= pifr_ccp_mode_t'(2'(m));
      for (int i = 0; i < 6; i++) begin
        pulse(6'h01 << i);
        chk_all;
        wr(FLAGS_OFF, 32'h00000000, 4'hF);
      end
    end
    // clock enable low freezes everything: pulses in that window are lost
    ce <= 1'b0;
    pulse(6'h3F);
    ce <= 1'b1;
    m_flg = 8'h00;
    chk_all;
    // random events, modes, strobes and writes anywhere
    for (int k = 0; k < 60; k++) begin
      mode <= pifr_ccp_mode_t'(2'($random(seed)));
      pulse(6'($random(seed)));
      wr(addrs[$unsigned($random(seed)) % 6], $random(seed), 4'($random(seed)));
      chk_all;
    end
    // all flags forced, alias clear, read-only write, then reset mid-run
    wr(ENABLES_OFF, 32'hFFFFFFFF, 4'hF);
    wr(CTRL_OFF, 32'h00000001, 4'hF);
    wr(FLAGS_OFF, 32'h000000FF, 4'hF);
    chk_all;
    wr(CLEAR_OFF, 32'h00000009, 4'hF);
    wr(PENDING_OFF, 32'h000000FF, 4'hF);
    chk_all;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {m_flg, m_en, m_gt} = 17'h00000;
    chk_all;
    end_sim;
  end
endmodule
`default_nettype wire
